/* phase_offset_calibration_ramp.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "phase_ramp_defines.svh"

module phase_offset_calibration_ramp
  import phase_ramp_pkg::*;
#(
  parameter int unsigned RAMP_STEP_P = 1,
  parameter int unsigned INTERVAL_P = `RAMP_INTERVAL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic holdover,
  output logic divider_reset,
  output logic [15:0] internal_offset,
  output logic [15:0] output_offset
);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [7:0] sync_monitor_config_reg;
  logic [15:0] phase_offset_reg;
  logic [15:0] int_offset_reg;
  logic [15:0] out_offset_reg;
  logic [15:0] target;
  logic [15:0] tick_cnt_reg;
  logic tick;
  logic holdover_reg;
  logic div_rst_reg;
  logic start_cal;
  logic access;
  logic wr;
  logic addr_ok;
  cal_state_t state_reg;
  ramp_status_t status;
  logic sel_config;
  logic sel_offset;
  logic sel_status;
  logic sel_phase;
  logic wr_config;
  logic wr_offset;
  logic rd_setup;
  logic offset_ramp_calibrate;
  logic seq_idle;
  logic in_cal;
  logic at_zero;
  logic at_prog;
  logic gradual;
  logic ramp_hold;
  logic go_up;
  logic go_down;
  logic signed [16:0] offset_gap;
  logic [31:0] rdata_next;

  // ----------------------------------------
  // Derived constants
  // ----------------------------------------
  // Interval terminal count and ramp step at the offset width
  localparam logic [15:0] TICK_LAST = 16'(INTERVAL_P - 1);
  localparam logic [15:0] STEP_SIZE = 16'(RAMP_STEP_P);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Bus phase qualifiers; the slave never inserts wait states
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;

  // One select per mapped word
  assign sel_config = (paddr == `OFS_SYNC_MONITOR_CONFIG);
  assign sel_offset = (paddr == `OFS_PHASE_OFFSET);
  assign sel_status = (paddr == `OFS_RAMP_STATUS);
  assign sel_phase = (paddr == `OFS_OUTPUT_PHASE);
  assign addr_ok = sel_config | sel_offset | sel_status | sel_phase;

  // Unmapped words answer with an error and take no write
  assign pslverr = access & ~addr_ok;
  assign wr_config = wr & sel_config;
  assign wr_offset = wr & sel_offset;

  assign start_cal = wr_config & pwdata[`BIT_CALIBRATE];

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // control bit storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_monitor_config_reg <= `RST_SYNC_MONITOR_CONFIG;
    end else if (wr_config) begin
      sync_monitor_config_reg <= pwdata[7:0];
    end
  end

  // Calibrate and gradual-ramp control bit
  assign offset_ramp_calibrate = sync_monitor_config_reg[`BIT_CALIBRATE];

  // Programmed phase offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_offset_reg <= `RST_PHASE_OFFSET;
    end else if (wr_offset) begin
      phase_offset_reg <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  // Sequencer view for software
  assign status.holdover = holdover_reg;
  assign status.calibrating = in_cal;
  assign status.ramping = state_reg[1] | state_reg[3] | state_reg[5];
  assign status.at_target = at_prog;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Word selected by the setup-phase address
  always_comb begin
    case (paddr)
      `OFS_SYNC_MONITOR_CONFIG: rdata_next = {24'h00_0000, sync_monitor_config_reg};
      `OFS_PHASE_OFFSET: rdata_next = {16'h0000, phase_offset_reg};
      `OFS_RAMP_STATUS: rdata_next = {28'h000_0000, status};
      `OFS_OUTPUT_PHASE: rdata_next = {int_offset_reg, out_offset_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Loaded in the setup cycle so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rdata_next;
    end
  end

  // ----------------------------------------
  // Ramp update interval
  // ----------------------------------------
  // interval divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end
  // One-cycle enable at the end of each interval
  assign tick = (tick_cnt_reg >= TICK_LAST);

  // ----------------------------------------
  // Calibration sequencer
  // ----------------------------------------
  // Ramp target follows the sequence phase
  always_comb begin
    case (state_reg)
      ST_TO_ZERO: target = 16'h0000;
      ST_DIV_RESET: target = 16'h0000;
      default: target = phase_offset_reg;
    endcase
  end

  // ----------------------------------------
  // Sequence flags
  // ----------------------------------------
  // Rest states, calibration in progress and ramp end points
  assign seq_idle = (state_reg == ST_IDLE) || (state_reg == ST_TRACK);
  assign in_cal = ~seq_idle;
  assign at_zero = (int_offset_reg == 16'h0000);
  assign at_prog = (int_offset_reg == phase_offset_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE, ST_TRACK: begin
          if (start_cal) begin
            state_reg <= ST_TO_ZERO;
          end else if (!at_prog) begin
            state_reg <= ST_TRACK;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_TO_ZERO: if (at_zero) state_reg <= ST_DIV_RESET;
        ST_DIV_RESET: state_reg <= ST_TO_PROG;
        ST_TO_PROG: if (at_prog) state_reg <= ST_EXIT;
        ST_EXIT: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Holdover and divider reset
  // ----------------------------------------
  // holdover control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holdover_reg <= 1'b0;
    end else if (start_cal && seq_idle) begin
      holdover_reg <= 1'b1;
    end else if (state_reg == ST_EXIT) begin
      holdover_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_rst_reg <= 1'b0;
    end else begin
      div_rst_reg <= (state_reg == ST_DIV_RESET);
    end
  end

  // ----------------------------------------
  // Offset ramp
  // ----------------------------------------
  // Two's complement gap, one bit wider so no distance aliases to a jump
  assign offset_gap = $signed({target[15], target}) - $signed({int_offset_reg[15], int_offset_reg});
  assign go_up = (offset_gap > $signed({1'b0, STEP_SIZE}));
  assign go_down = (offset_gap < -$signed({1'b0, STEP_SIZE}));

  // Gradual while the bit is set or a calibration runs
  assign gradual = offset_ramp_calibrate | in_cal;

  // Offset held while dividers restart and while the sequence closes
  assign ramp_hold = (state_reg == ST_DIV_RESET) || (state_reg == ST_EXIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_offset_reg <= `RST_PHASE_OFFSET;
    end else if (!ramp_hold && tick) begin
      if (!gradual) begin
        int_offset_reg <= target; // Bit clear: step directly
      end else if (go_up) begin
        int_offset_reg <= int_offset_reg + STEP_SIZE;
      end else if (go_down) begin
        int_offset_reg <= int_offset_reg - STEP_SIZE;
      end else begin
        int_offset_reg <= target;
      end
    end
  end

  // ----------------------------------------
  // Visible phase
  // ----------------------------------------
  // frozen visible phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_offset_reg <= `RST_PHASE_OFFSET;
    end else if (!status.calibrating && state_reg != ST_EXIT) begin
      out_offset_reg <= int_offset_reg;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Sequencer outputs
  assign holdover = holdover_reg;
  assign divider_reset = div_rst_reg;

  // Internal and visible offsets
  assign internal_offset = int_offset_reg;
  assign output_offset = out_offset_reg;

endmodule : phase_offset_calibration_ramp

/* phase_ramp_defines.svh */
`ifndef PHASE_RAMP_DEFINES_SVH
`define PHASE_RAMP_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_SYNC_MONITOR_CONFIG 12'h07c
`define OFS_PHASE_OFFSET 12'h080
`define OFS_RAMP_STATUS 12'h084
`define OFS_OUTPUT_PHASE 12'h088

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define RST_SYNC_MONITOR_CONFIG 8'h2b
`define RST_PHASE_OFFSET 16'h0000
`define BIT_CALIBRATE 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_HZ 25000000
`define RAMP_INTERVAL_NS 1000
`define RAMP_INTERVAL_CYCLES ((`RAMP_INTERVAL_NS * (`CLK_FREQ_HZ / 1000000)) / 1000)
`define RAMP_STEP 16'h0001

`endif

/* phase_ramp_pkg.sv */
package phase_ramp_pkg;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_TO_ZERO = 6'b00_0010,
    ST_DIV_RESET = 6'b00_0100,
    ST_TO_PROG = 6'b00_1000,
    ST_EXIT = 6'b01_0000,
    ST_TRACK = 6'b10_0000
  } cal_state_t;

  // Status seen by software
  typedef struct packed {
    logic holdover;
    logic calibrating;
    logic ramping;
    logic at_target;
  } ramp_status_t;

endpackage : phase_ramp_pkg

/* phase_ramp_monitor.sv */
`timescale 1ns/1ps
`include "phase_ramp_defines.svh"
module phase_ramp_monitor
  import phase_ramp_pkg::*;
#(
  parameter int unsigned RAMP_STEP_P = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic holdover,
  input wire logic divider_reset,
  input wire logic [15:0] internal_offset,
  input wire logic [15:0] output_offset
);
  logic acc;
  logic mapped;
  // Access phase and address decode
  assign acc = psel && penable;
  assign mapped = paddr inside {`OFS_SYNC_MONITOR_CONFIG, `OFS_PHASE_OFFSET, `OFS_RAMP_STATUS, `OFS_OUTPUT_PHASE};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (acc |-> pready) else $error("pready low in access");
  slverr_map_a: assert property (acc && !mapped |-> pslverr) else $error("unmapped without pslverr");
  slverr_ok_a: assert property (acc && mapped |-> !pslverr) else $error("pslverr on mapped");
  hold_start_a: assert property (acc && pwrite && paddr == `OFS_SYNC_MONITOR_CONFIG && pwdata[`BIT_CALIBRATE]
    && !holdover |=> holdover) else $error("holdover not entered");
  out_freeze_a: assert property (holdover && $past(holdover) |-> $stable(output_offset))
    else $error("output offset moved");
  div_pulse_a: assert property (divider_reset |=> !divider_reset) else $error("long divider pulse");
  div_zero_a: assert property (divider_reset |-> holdover && internal_offset == 16'h0000)
    else $error("divider reset off zero");
  step_bound_a: assert property (holdover && $past(holdover) && $changed(internal_offset) |->
    (16'(internal_offset - $past(internal_offset)) <= 16'(RAMP_STEP_P)) ||
    (16'($past(internal_offset) - internal_offset) <= 16'(RAMP_STEP_P))) else $error("ramp step too big");
  div_c: cover property (divider_reset);
  exit_c: cover property ($fell(holdover));
  err_c: cover property (acc && pslverr);
endmodule : phase_ramp_monitor

bind phase_offset_calibration_ramp phase_ramp_monitor #(.RAMP_STEP_P(RAMP_STEP_P)) mon (.*);

/* phase_offset_calibration_ramp_tb_top.sv */
`timescale 1ns/1ps
module phase_offset_calibration_ramp_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, div_seen = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, holdover, divider_reset;
  logic [15:0] internal_offset, output_offset, v, w;
  logic [32:0] exp_q[$];
  int error_cnt = 0, samples_checked = 0, seed = 52;
  // Clock
  always #20 pclk = ~pclk;
  phase_offset_calibration_ramp #(.INTERVAL_P(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .holdover(holdover), .divider_reset(divider_reset), .internal_offset(internal_offset),
    .output_offset(output_offset));
  task check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task apb(input logic w_en, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w_en; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin error_cnt++; print_verdict; end
    psel <= 0; penable <= 0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 32'h0000_0000);
  endtask : rd
  task wait_hold(input logic val);
    int n;
    n = 0;
    while (holdover !== val && n < 4000) begin @(posedge pclk); n++; end
    if (n >= 4000) begin error_cnt++; print_verdict; end
  endtask : wait_hold
  // Read results compared against oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
    if (divider_reset === 1'b1) div_seen <= 1;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(12'h07c, {1'b0, 32'h0000_002b});
    apb(1, 12'h0f0, 32'hffff_ffff);
    rd(12'h0f0, {1'b1, 32'h0000_0000});
    v = (16'($random(seed)) & 16'h007f) | 16'h0010;
    apb(1, 12'h080, {16'h0000, v});
    repeat (8) @(posedge pclk);
    rd(12'h088, {1'b0, v, v});
    apb(1, 12'h07c, 32'h0000_00ab);
    wait_hold(1'b1);
    check({32'h0000_0000, holdover}, 33'h0_0000_0001);
    rd(12'h084, {1'b0, 32'h0000_000e});
    wait_hold(1'b0);
    check({32'h0000_0000, div_seen}, 33'h0_0000_0001);
    check({17'h0_0000, output_offset}, {17'h0_0000, v});
    repeat (4) @(posedge pclk);
    rd(12'h088, {1'b0, v, v});
    rd(12'h07c, {1'b0, 32'h0000_00ab});
    rd(12'h084, {1'b0, 32'h0000_0001});
    w = v + 16'h0020;
    apb(1, 12'h080, {16'h0000, w});
    repeat (3) @(posedge pclk);
    check({32'h0000_0000, internal_offset != w}, 33'h0_0000_0001);
    repeat (200) @(posedge pclk);
    rd(12'h088, {1'b0, w, w});
    repeat (2) @(posedge pclk);
    print_verdict;
  end
endmodule : phase_offset_calibration_ramp_tb_top
